// *** src/ppfs_pkg.sv ***
// ppfs_pkg: register map, control field layout and reset values of the pin select block
package ppfs_pkg;
    // ==========================================================
    // register indices, byte address is four times the index
    localparam logic [29:0] IDX_PB_DIR = 30'h000e_e00a;
    localparam logic [29:0] IDX_PB_VAL = 30'h000f_ffda;
    localparam logic [29:0] IDX_SEL_CTRL = 30'h0000_0100;
    localparam logic [29:0] IDX_PA_VAL = 30'h0000_0101;

    // ==========================================================
    // reset and fixed read values
    localparam logic [7:0] PB_DIR_RST = 8'h00;
    localparam logic [7:0] PB_VAL_RST = 8'h00;
    localparam logic [7:0] PB_DIR_READ = 8'hff;
    localparam logic [2:0] PA_VAL_RST = 3'h0;
    localparam logic [31:0] SEL_CTRL_RST = 32'h0000_3000;

    // ==========================================================
    // select control fields
    localparam int unsigned F_IO0 = 0;
    localparam int unsigned F_IO1 = 3;
    localparam int unsigned F_IO2 = 6;
    localparam int unsigned F_PWMODE0 = 9;
    localparam int unsigned F_PWMODE1 = 10;
    localparam int unsigned F_PWMODE2 = 11;
    localparam int unsigned F_A21EN = 12;
    localparam int unsigned F_A22EN = 13;
    localparam int unsigned F_DIR = 14;
    localparam int unsigned F_PE = 17;
    localparam int unsigned F_PSC0 = 20;
    localparam int unsigned F_PSC1 = 23;
    localparam int unsigned F_PSC2 = 26;
    localparam int unsigned F_CKS = 29;

    // ==========================================================
    // port A pin slots and codes
    localparam int unsigned PA2 = 0;
    localparam int unsigned PA5 = 1;
    localparam int unsigned PA6 = 2;
    localparam logic [2:0] PSC_EXT_C = 3'h6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ppfs_pkg

// *** src/ppfs_top.sv ***
// ppfs_top: port A pin function select and port B direction/data with an AXI4-Lite slave
// Behaviour
// (RULE_01) address bit 21 on pin 6 when enabled
// (RULE_02) pin 6 drives channel 2 compare output A
// (RULE_03) pin 6 otherwise input, output or pattern
// (RULE_04) pin 6 feeds channel 2 capture A
// (RULE_05) address bit 22 on pin 5 when enabled
// (RULE_06) pin 5 compare B, else input/output/pattern
// (RULE_07) pin 5 feeds channel 1 capture B
// (RULE_08) pin 2 compare A, else input/output/pattern
// (RULE_09) pin 2 feeds channel 0 capture A
// (RULE_10) pin 2 feeds external clock C
// (RULE_11) port B direction bit selects output
// (RULE_12) port B direction write-only, reads ones
// (RULE_13) direction cleared by reset, hardware standby
// (RULE_14) software sets direction for pattern output
// (RULE_15) port B data readable, writable, resets zero
// (RULE_16) decode from register bits, next cycle
// (RULE_17) output drives data bit, input reads pin
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ppfs_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic hw_standby,
    input wire logic addr21_in,
    input wire logic addr22_in,
    input wire logic t0_cmp_a,
    input wire logic t1_cmp_b,
    input wire logic t2_cmp_a,
    input wire logic [2:0] pat_in,
    output logic t0_cap_a,
    output logic t1_cap_b,
    output logic t2_cap_a,
    output logic ext_clk_c,
    input wire logic [2:0] pa_in,
    output logic [2:0] pa_out,
    output logic [2:0] pa_oe,
    input wire logic [7:0] pb_in,
    output logic [7:0] pb_out,
    output logic [7:0] pb_oe
);
    // ==========================================================
    // state
    logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
    logic [29:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic awready_ff, nxt_awready, wready_ff, nxt_wready;
    logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready;
    logic rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [7:0] pb_dir_ff, nxt_pb_dir, pb_val_ff, nxt_pb_val;
    logic [2:0] pa_val_ff, nxt_pa_val;
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [2:0] pa_out_ff, nxt_pa_out, pa_oe_ff, nxt_pa_oe;
    logic [7:0] pb_out_ff, pb_oe_ff;
    logic t0_cap_ff, t1_cap_ff, t2_cap_ff, clkc_ff;
    logic nxt_t0_cap, nxt_t1_cap, nxt_t2_cap, nxt_clkc;
    logic ch0_out, ch1_out, ch2_out, clkc_sel;
    logic [2:0] io0, io1, io2, pa_dir, pa_pe, pa_rd;
    logic [7:0] pb_rd;

    // ==========================================================
    // pin function decode
    always_comb begin
        io0 = ctrl_ff[ppfs_pkg::F_IO0 +: 3];
        io1 = ctrl_ff[ppfs_pkg::F_IO1 +: 3];
        io2 = ctrl_ff[ppfs_pkg::F_IO2 +: 3];
        pa_dir = ctrl_ff[ppfs_pkg::F_DIR +: 3];
        pa_pe = ctrl_ff[ppfs_pkg::F_PE +: 3];
        ch0_out = ctrl_ff[ppfs_pkg::F_PWMODE0] | (~io0[2] & (|io0[1:0]));
        ch1_out = ~io1[2] & (|io1[1:0]);
        ch2_out = ctrl_ff[ppfs_pkg::F_PWMODE2] | (~io2[2] & (|io2[1:0]));
        clkc_sel = (ctrl_ff[ppfs_pkg::F_PSC0 +: 3] == ppfs_pkg::PSC_EXT_C)
                 | (ctrl_ff[ppfs_pkg::F_PSC1 +: 3] == ppfs_pkg::PSC_EXT_C)
                 | (ctrl_ff[ppfs_pkg::F_PSC2 +: 3] == ppfs_pkg::PSC_EXT_C)
                 | (ctrl_ff[ppfs_pkg::F_CKS + 2] & (|ctrl_ff[ppfs_pkg::F_CKS +: 2]));
        // general function: direction picks drive, pattern enable picks source
        nxt_pa_oe = pa_dir; // [RULE_03] [RULE_16]
        nxt_pa_out = (pa_pe & pat_in) | (~pa_pe & pa_val_ff); // [RULE_17]
        if (ch0_out) begin
            nxt_pa_oe[ppfs_pkg::PA2] = 1'b1; // [RULE_08]
            nxt_pa_out[ppfs_pkg::PA2] = t0_cmp_a;
        end
        if (ch1_out) begin
            nxt_pa_oe[ppfs_pkg::PA5] = 1'b1; // [RULE_06]
            nxt_pa_out[ppfs_pkg::PA5] = t1_cmp_b;
        end
        if (ch2_out) begin
            nxt_pa_oe[ppfs_pkg::PA6] = 1'b1; // [RULE_02]
            nxt_pa_out[ppfs_pkg::PA6] = t2_cmp_a;
        end
        // address lines win over every timer and port choice
        if (!ctrl_ff[ppfs_pkg::F_A22EN]) begin
            nxt_pa_oe[ppfs_pkg::PA5] = 1'b1; // [RULE_05]
            nxt_pa_out[ppfs_pkg::PA5] = addr22_in;
        end
        if (!ctrl_ff[ppfs_pkg::F_A21EN]) begin
            nxt_pa_oe[ppfs_pkg::PA6] = 1'b1; // [RULE_01]
            nxt_pa_out[ppfs_pkg::PA6] = addr21_in;
        end
        // capture and clock inputs read as zero while not selected
        nxt_t0_cap = io0[2] & pa_in[ppfs_pkg::PA2]; // [RULE_09]
        nxt_t1_cap = io1[2] & ~ctrl_ff[ppfs_pkg::F_PWMODE1] & pa_in[ppfs_pkg::PA5]; // [RULE_07]
        nxt_t2_cap = io2[2] & pa_in[ppfs_pkg::PA6]; // [RULE_04]
        nxt_clkc = clkc_sel & pa_in[ppfs_pkg::PA2]; // [RULE_10]
        pa_rd = (pa_dir & pa_val_ff) | (~pa_dir & pa_in); // [RULE_17]
        pb_rd = (pb_dir_ff & pb_val_ff) | (~pb_dir_ff & pb_in); // [RULE_17]
    end

    // ==========================================================
    // bus slave and register file
    always_comb begin
        nxt_aw_got = aw_got_ff;
        nxt_w_got = w_got_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rresp = rresp_ff;
        nxt_rdata = rdata_ff;
        nxt_pb_dir = pb_dir_ff;
        nxt_pb_val = pb_val_ff;
        nxt_pa_val = pa_val_ff;
        nxt_ctrl = ctrl_ff;
        if (awvalid && awready_ff) begin
            nxt_aw_got = 1'b1;
            nxt_awaddr = awaddr[31:2];
        end
        if (wvalid && wready_ff) begin
            nxt_w_got = 1'b1;
            nxt_wdata = wdata;
            nxt_wstrb = wstrb;
        end
        if (bvalid_ff && bready) begin
            nxt_bvalid = 1'b0;
        end
        // the write lands one cycle after both halves are held
        if (aw_got_ff && w_got_ff && !bvalid_ff) begin
            nxt_aw_got = 1'b0;
            nxt_w_got = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = ppfs_pkg::RESP_OKAY;
            case (awaddr_ff)
                ppfs_pkg::IDX_PB_DIR: begin
                    if (wstrb_ff[0]) nxt_pb_dir = wdata_ff[7:0]; // [RULE_12]
                end
                ppfs_pkg::IDX_PB_VAL: begin
                    if (wstrb_ff[0]) nxt_pb_val = wdata_ff[7:0]; // [RULE_15]
                end
                ppfs_pkg::IDX_PA_VAL: begin
                    if (wstrb_ff[0]) nxt_pa_val = wdata_ff[2:0];
                end
                ppfs_pkg::IDX_SEL_CTRL: begin
                    for (int i = 0; i < 4; i++) begin
                        if (wstrb_ff[i]) nxt_ctrl[8*i +: 8] = wdata_ff[8*i +: 8];
                    end
                end
                default: nxt_bresp = ppfs_pkg::RESP_SLVERR;
            endcase
        end
        // standby clears direction even against a write in the same cycle
        if (hw_standby) begin
            nxt_pb_dir = ppfs_pkg::PB_DIR_RST; // [RULE_13]
        end
        if (rvalid_ff && rready) begin
            nxt_rvalid = 1'b0;
        end
        if (arvalid && arready_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = ppfs_pkg::RESP_OKAY;
            nxt_rdata = 32'h0000_0000;
            case (araddr[31:2])
                ppfs_pkg::IDX_PB_DIR: nxt_rdata[7:0] = ppfs_pkg::PB_DIR_READ; // [RULE_12]
                ppfs_pkg::IDX_PB_VAL: nxt_rdata[7:0] = pb_rd; // [RULE_15]
                ppfs_pkg::IDX_PA_VAL: nxt_rdata[2:0] = pa_rd;
                ppfs_pkg::IDX_SEL_CTRL: nxt_rdata = ctrl_ff;
                default: nxt_rresp = ppfs_pkg::RESP_SLVERR;
            endcase
        end
        nxt_awready = !nxt_aw_got && !nxt_bvalid;
        nxt_wready = !nxt_w_got && !nxt_bvalid;
        nxt_arready = !nxt_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 30'h0000_0000;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= ppfs_pkg::RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rresp_ff <= ppfs_pkg::RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
            pb_dir_ff <= ppfs_pkg::PB_DIR_RST; // [RULE_13]
            pb_val_ff <= ppfs_pkg::PB_VAL_RST; // [RULE_15]
            pa_val_ff <= ppfs_pkg::PA_VAL_RST;
            ctrl_ff <= ppfs_pkg::SEL_CTRL_RST;
            pa_out_ff <= 3'h0;
            pa_oe_ff <= 3'h0;
            pb_out_ff <= 8'h00;
            pb_oe_ff <= 8'h00;
            t0_cap_ff <= 1'b0;
            t1_cap_ff <= 1'b0;
            t2_cap_ff <= 1'b0;
            clkc_ff <= 1'b0;
        end else if (ce) begin
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
            pb_dir_ff <= nxt_pb_dir;
            pb_val_ff <= nxt_pb_val;
            pa_val_ff <= nxt_pa_val;
            ctrl_ff <= nxt_ctrl;
            pa_out_ff <= nxt_pa_out;
            pa_oe_ff <= nxt_pa_oe;
            pb_out_ff <= pb_val_ff; // [RULE_17]
            pb_oe_ff <= pb_dir_ff; // [RULE_11]
            t0_cap_ff <= nxt_t0_cap;
            t1_cap_ff <= nxt_t1_cap;
            t2_cap_ff <= nxt_t2_cap;
            clkc_ff <= nxt_clkc;
        end
    end

    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rresp = rresp_ff;
    assign rdata = rdata_ff;
    assign pa_out = pa_out_ff;
    assign pa_oe = pa_oe_ff;
    assign pb_out = pb_out_ff;
    assign pb_oe = pb_oe_ff;
    assign t0_cap_a = t0_cap_ff;
    assign t1_cap_b = t1_cap_ff;
    assign t2_cap_a = t2_cap_ff;
    assign ext_clk_c = clkc_ff;

    // ==========================================================
    // assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_pa6_addr;
        ce && !ctrl_ff[ppfs_pkg::F_A21EN]
        |=> pa_oe[ppfs_pkg::PA6] && pa_out[ppfs_pkg::PA6] == $past(addr21_in);
    endproperty
    a_pa6_addr: assert property (p_pa6_addr) else $error("pin 6 lost address 21"); // [RULE_01]
    property p_pa6_cmp;
        ce && ctrl_ff[ppfs_pkg::F_A21EN] && ch2_out
        |=> pa_oe[ppfs_pkg::PA6] && pa_out[ppfs_pkg::PA6] == $past(t2_cmp_a);
    endproperty
    a_pa6_cmp: assert property (p_pa6_cmp) else $error("pin 6 compare wrong"); // [RULE_02]
    property p_pa6_gen;
        ce && ctrl_ff[ppfs_pkg::F_A21EN] && !ch2_out && !pa_dir[ppfs_pkg::PA6]
        |=> !pa_oe[ppfs_pkg::PA6];
    endproperty
    a_pa6_gen: assert property (p_pa6_gen) else $error("pin 6 driven as input"); // [RULE_03]
    property p_t2_cap;
        ce && io2[2] |=> t2_cap_a == $past(pa_in[ppfs_pkg::PA6]);
    endproperty
    a_t2_cap: assert property (p_t2_cap) else $error("capture A ch2 wrong"); // [RULE_04]
    property p_pa5_addr;
        ce && !ctrl_ff[ppfs_pkg::F_A22EN]
        |=> pa_oe[ppfs_pkg::PA5] && pa_out[ppfs_pkg::PA5] == $past(addr22_in);
    endproperty
    a_pa5_addr: assert property (p_pa5_addr) else $error("pin 5 lost address 22"); // [RULE_05]
    property p_t1_cap;
        ce && ctrl_ff[ppfs_pkg::F_PWMODE1] |=> !t1_cap_b;
    endproperty
    a_t1_cap: assert property (p_t1_cap) else $error("capture B in pwm mode"); // [RULE_07]
    property p_pa2_cmp;
        ce && ch0_out |=> pa_oe[ppfs_pkg::PA2] && pa_out[ppfs_pkg::PA2] == $past(t0_cmp_a);
    endproperty
    a_pa2_cmp: assert property (p_pa2_cmp) else $error("pin 2 compare wrong"); // [RULE_08]
    property p_clkc;
        ce && !clkc_sel |=> !ext_clk_c;
    endproperty
    a_clkc: assert property (p_clkc) else $error("clock C without select"); // [RULE_10]
    property p_pb_dir;
        ce |=> pb_oe == $past(pb_dir_ff);
    endproperty
    a_pb_dir: assert property (p_pb_dir) else $error("port B enable mismatch"); // [RULE_11]
    property p_dir_read;
        ce && arvalid && arready && araddr[31:2] == ppfs_pkg::IDX_PB_DIR
        |=> rvalid && rdata == {24'h00_0000, ppfs_pkg::PB_DIR_READ};
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("direction read not ones"); // [RULE_12]
    property p_standby;
        ce && hw_standby |=> pb_dir_ff == ppfs_pkg::PB_DIR_RST;
    endproperty
    a_standby: assert property (p_standby) else $error("standby kept direction"); // [RULE_13]

    c_write: cover property (bvalid && bready && bresp == ppfs_pkg::RESP_OKAY);
    c_read: cover property (rvalid && rready && rresp == ppfs_pkg::RESP_OKAY);
    c_addr21: cover property (!ctrl_ff[ppfs_pkg::F_A21EN] && pa_oe[ppfs_pkg::PA6]);
    c_clkc: cover property (clkc_sel && ext_clk_c);
endmodule : ppfs_top
`default_nettype wire

// *** verif/ppfs_pins.sv ***
// ppfs_pins: external circuitry on the port pins, resolving each pin level
`timescale 1ns/10ps
`default_nettype none
module ppfs_pins (
    input wire logic [2:0] pa_out,
    input wire logic [2:0] pa_oe,
    input wire logic [2:0] pa_drive,
    input wire logic [7:0] pb_out,
    input wire logic [7:0] pb_oe,
    input wire logic [7:0] pb_drive,
    output logic [2:0] pa_in,
    output logic [7:0] pb_in
);
    // ==========================================================
    // wire level
    // undriven pins carry the outside level, redrawn every trial so stale values show
    assign pa_in = (pa_oe & pa_out) | (~pa_oe & pa_drive);
    assign pb_in = (pb_oe & pb_out) | (~pb_oe & pb_drive);
endmodule : ppfs_pins
`default_nettype wire

// *** verif/ppfs_top_bench.sv ***
// ppfs_top_bench: self-checking bench for the pin function select block
`timescale 1ns/10ps
`default_nettype none
module ppfs_top_bench;
    // ==========================================================
    // signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic hw_standby = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000, araddr = 32'h0000_0000;
    logic [3:0] wstrb = 4'hf;
    logic addr21_in = 1'b0, addr22_in = 1'b0, t0_cmp_a = 1'b0, t1_cmp_b = 1'b0, t2_cmp_a = 1'b0;
    logic [2:0] pat_in = 3'h0, pa_drive = 3'h0;
    logic [7:0] pb_drive = 8'h00;
    logic awready, wready, bvalid, arready, rvalid, t0_cap_a, t1_cap_b, t2_cap_a, ext_clk_c;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] pa_in, pa_out, pa_oe;
    logic [7:0] pb_in, pb_out, pb_oe;
    int num_errors = 0, samples_checked = 0, cycles = 0;
    localparam logic [31:0] A_DIR = {ppfs_pkg::IDX_PB_DIR, 2'b00};
    localparam logic [31:0] A_VAL = {ppfs_pkg::IDX_PB_VAL, 2'b00};
    localparam logic [31:0] A_CTL = {ppfs_pkg::IDX_SEL_CTRL, 2'b00};
    localparam logic [31:0] A_PA = {ppfs_pkg::IDX_PA_VAL, 2'b00};
    localparam logic [31:0] A_BAD = 32'h0000_0800;

    ppfs_top dut (
        .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .hw_standby, .addr21_in, .addr22_in, .t0_cmp_a, .t1_cmp_b, .t2_cmp_a, .pat_in,
        .t0_cap_a, .t1_cap_b, .t2_cap_a, .ext_clk_c, .pa_in, .pa_out, .pa_oe, .pb_in, .pb_out,
        .pb_oe
    );
    ppfs_pins pins (.pa_out, .pa_oe, .pa_drive, .pb_out, .pb_oe, .pb_drive, .pa_in, .pb_in);

    // ==========================================================
    // clock, timeout and helpers
    initial begin
        forever #5 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one shift per bit so successive draws are not shifted copies of each other
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        logic [31:0] x;
        x = v;
        for (int i = 0; i < 32; i++) x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
        return x;
    endfunction : lfsr

    // waits are bounded by the global cycle ceiling, not by a guessed latency
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd

    // pin slots [0]=pin2 [1]=pin5 [2]=pin6
    function automatic void exp_pins(input logic [31:0] c, input logic [2:0] d, e, pt, cm,
        input logic a21, a22, output logic [2:0] oe, out, lvl, cap, output logic ck);
        logic [2:0] cs;
        cs[0] = c[9] | (!c[2] && c[1:0] != 2'b00);
        cs[1] = !c[5] && c[4:3] != 2'b00;
        cs[2] = c[11] | (!c[8] && c[7:6] != 2'b00);
        for (int i = 0; i < 3; i++) begin
            oe[i] = cs[i] | c[14 + i];
            out[i] = cs[i] ? cm[i] : (c[17 + i] ? pt[i] : d[i]);
        end
        if (!c[13]) {oe[1], out[1]} = {1'b1, a22};
        if (!c[12]) {oe[2], out[2]} = {1'b1, a21};
        lvl = (oe & out) | (~oe & e);
        cap = {c[8], c[5] & !c[10], c[2]} & lvl;
        ck = (c[22:20] == ppfs_pkg::PSC_EXT_C || c[25:23] == ppfs_pkg::PSC_EXT_C
            || c[28:26] == ppfs_pkg::PSC_EXT_C || (c[31] && c[30:29] != 2'b00)) & lvl[0];
    endfunction : exp_pins

    // ==========================================================
    // main sequence
    initial begin
        logic [31:0] s, c, d;
        logic [1:0] r;
        logic [2:0] oe, out, lvl, cap, pd;
        logic [7:0] dir, val;
        logic ck;
        s = 32'h0001_3781;
        val = 8'h00;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(pb_oe, ppfs_pkg::PB_DIR_RST);
        chk(pb_out, ppfs_pkg::PB_VAL_RST);
        rd(A_CTL, d, r);
        chk(d, ppfs_pkg::SEL_CTRL_RST);
        wr(A_BAD, 32'hffff_ffff, r);
        chk(r, ppfs_pkg::RESP_SLVERR);
        rd(A_BAD, d, r);
        chk(r, ppfs_pkg::RESP_SLVERR);
        chk(d, 32'h0000_0000);
        for (int k = 0; k < 80; k++) begin
            s = lfsr(s);
            c = s;
            s = lfsr(s);
            {pa_drive, pat_in, addr21_in, addr22_in, t0_cmp_a, t1_cmp_b, t2_cmp_a} <= s[10:0];
            pb_drive <= s[31:24];
            {pd, dir} = s[21:11];
            s = lfsr(s);
            val = s[7:0];
            wr(A_CTL, c, r);
            chk(r, ppfs_pkg::RESP_OKAY);
            wr(A_PA, {29'h0, pd}, r);
            wr(A_DIR, {24'h00_0000, dir}, r);
            wr(A_VAL, {24'h00_0000, val}, r);
            repeat (3) @(posedge aclk);
            exp_pins(c, pd, pa_drive, pat_in, {t2_cmp_a, t1_cmp_b, t0_cmp_a}, addr21_in,
                addr22_in, oe, out, lvl, cap, ck);
            chk(pa_oe, oe);
            chk(pa_out & oe, out & oe);
            chk({t2_cap_a, t1_cap_b, t0_cap_a}, cap);
            chk(ext_clk_c, ck);
            chk(pb_oe, dir);
            chk(pb_out & dir, val & dir);
            rd(A_VAL, d, r);
            chk(d, (dir & val) | (~dir & pb_drive));
            rd(A_DIR, d, r);
            chk(d, {24'h00_0000, ppfs_pkg::PB_DIR_READ});
            rd(A_PA, d, r);
            chk(d, (c[16:14] & pd) | (~c[16:14] & lvl));
            rd(A_CTL, d, r);
            chk(d, c);
        end
        wr(A_DIR, 32'h0000_00a5, r);
        #1 chk(pb_oe, 8'ha5);
        // standby must not act while the clock enable holds every flop
        @(posedge aclk);
        ce <= 1'b0;
        hw_standby <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(pb_oe, 8'ha5);
        ce <= 1'b1;
        @(posedge aclk);
        hw_standby <= 1'b0;
        repeat (2) @(posedge aclk);
        chk(pb_oe, ppfs_pkg::PB_DIR_RST);
        chk(pb_out, val);
        wr(A_DIR, 32'h0000_00ff, r);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(pb_oe, ppfs_pkg::PB_DIR_RST);
        chk(pb_out, ppfs_pkg::PB_VAL_RST);
        end_sim();
    end
endmodule : ppfs_top_bench
`default_nettype wire
